// ---- gdr_pkg.sv ----
// gdr_pkg: constants and types of the gauge display and reset block
// ------------------------------------------------------------
// Contract
// - a zero write to program_pin_data_reg then a zero write to last_measured_discharge resets.
// - reset loads last_measured_discharge from full capacity, clears five values, sets the flag.
// - battery_voltage_reg at 7eh is refreshed about once a second from battery_sense_input.
// - the battery voltage code means 1.2 V times the code divided by 256.
// - in relative mode one led lights per 20 percent of last_measured_discharge held.
// - in absolute mode one led lights per 20 percent of the programmed full capacity.
// - control pin high keeps leds dark; floating lights them only on fast charge, fast discharge or during the hold time after low.
// - control pin held low keeps the leds active continuously.
// - after the control pin is released from low the leds stay active 4 seconds more.
// - leds 1, 3, 5 form one bank and leds 2, 4 the other, driven alternately.
// - the banks are modulated at about 320 Hz, each active 30 percent of the period.
// - led 1 blinks at 4 Hz on low battery voltage or charge under 10 percent of the reference.
// ------------------------------------------------------------
package gdr_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ        = 20000;
   localparam int CLK_MHZ        = 20;
   localparam int BATTV_MS       = 1000;
   localparam int BATTV_CYC      = BATTV_MS * CLK_KHZ;
   localparam int HOLD_MS        = 4000;
   localparam int HOLD_CYC       = HOLD_MS * CLK_KHZ;
   localparam int MOD_HZ         = 320;
   localparam int MOD_CYC        = (CLK_KHZ * 1000) / MOD_HZ;
   localparam int MOD_DUTY_PCT   = 30;
   localparam int BLINK_HZ       = 4;
   localparam int BLINK_HALF_CYC = (CLK_KHZ * 1000) / (2 * BLINK_HZ);
   localparam int HDQ_BRK_US     = 190;
   localparam int HDQ_SAMP_US    = 75;
   localparam int HDQ_RSP_US     = 200;
   localparam int HDQ_BIT_US     = 200;
   localparam int HDQ_STRT_US    = 40;
   localparam int HDQ_ZERO_US    = 120;
   localparam logic [12:0] HDQ_BRK_CYC  = 13'(HDQ_BRK_US * CLK_MHZ);
   localparam logic [12:0] HDQ_SAMP_CYC = 13'(HDQ_SAMP_US * CLK_MHZ);
   localparam logic [12:0] HDQ_RSP_CYC  = 13'(HDQ_RSP_US * CLK_MHZ);
   localparam logic [12:0] HDQ_BIT_CYC  = 13'(HDQ_BIT_US * CLK_MHZ);
   localparam logic [12:0] HDQ_STRT_CYC = 13'(HDQ_STRT_US * CLK_MHZ);
   localparam logic [12:0] HDQ_ZERO_CYC = 13'(HDQ_ZERO_US * CLK_MHZ);
   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam logic [6:0] A_AVAIL_HI  = 7'h03;
   localparam logic [6:0] A_MEAS_DSG  = 7'h05;
   localparam logic [6:0] A_OUT_CTL   = 7'h0a;
   localparam logic [6:0] A_LOAD_COMP = 7'h0e;
   localparam logic [6:0] A_AVAIL_LO  = 7'h17;
   localparam logic [6:0] A_PROG_PIN  = 7'h7b;
   localparam logic [6:0] A_FLAGS     = 7'h7c;
   localparam logic [6:0] A_CTRL      = 7'h7d;
   localparam logic [6:0] A_BATT_V    = 7'h7e;
   localparam int FLG_RESET_IND = 0;
   localparam int FLG_VALID_DSG = 1;
   localparam int CTRL_ABS_BIT  = 0;
   localparam int OVR_EN_BIT    = 0;
   localparam int OVR_LED_LSB   = 1;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [7:0] FULL_CAP_DEF = 8'hc0;
   localparam logic [7:0] LOW_V1_DEF   = 8'h9a;
   // ------------------------------------------------------------
   // display
   // ------------------------------------------------------------
   localparam int LED_N        = 5;
   localparam int LED_STEP_PCT = 20;
   localparam int LOW_PCT      = 10;
   localparam logic [4:0] BANK_A_MASK = 5'h15;
   localparam logic [4:0] BANK_B_MASK = 5'h0a;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       stb;
      logic [6:0] addr;
      logic [7:0] data;
   } gdr_wr_t;
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_RX   = 4'b0010,
      H_GAP  = 4'b0100,
      H_TX   = 4'b1000
   } gdr_hdq_st_t;
endpackage

// ---- gdr_hdq.sv ----
// gdr_hdq: single-wire serial slave giving register reads and writes
`timescale 1ns/10ps
`default_nettype none
module gdr_hdq (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // serial pin
   input  wire logic        hdq_in,
   output logic             hdq_oe_out,
   // register side
   input  wire logic [7:0]  rd_data_in,
   output logic [6:0]       rd_addr_out,
   output gdr_pkg::gdr_wr_t wr_out
);
   logic [2:0]           sync_q;
   logic                 pin;
   logic                 fall;
   gdr_pkg::gdr_hdq_st_t st_q, st_d;
   logic [12:0]          tcnt_q, tcnt_d, low_q, low_d;
   logic [15:0]          sr_q, sr_d;
   logic [4:0]           bitn_q, bitn_d;
   logic                 run_q, run_d, brk_q, brk_d, oe_d;
   logic [6:0]           addr_q, addr_d;
   gdr_pkg::gdr_wr_t     wr_d;

   assign pin  = sync_q[1];
   assign fall = sync_q[2] & ~sync_q[1];

   always_comb begin
      st_d   = st_q;
      tcnt_d = tcnt_q;
      sr_d   = sr_q;
      bitn_d = bitn_q;
      run_d  = run_q;
      brk_d  = brk_q;
      addr_d = addr_q;
      wr_d   = '0;
      oe_d   = 1'b0;
      low_d  = pin ? 13'h0000 : ((low_q == gdr_pkg::HDQ_BRK_CYC) ? low_q : low_q + 13'h0001);
      case (st_q)
         gdr_pkg::H_IDLE: begin
            if (brk_q && pin) begin
               st_d   = gdr_pkg::H_RX;
               brk_d  = 1'b0;
               bitn_d = 5'h00;
               run_d  = 1'b0;
            end
         end
         gdr_pkg::H_RX: begin
            if (fall) begin
               run_d  = 1'b1;
               tcnt_d = 13'h0000;
            end else if (run_q) begin
               tcnt_d = tcnt_q + 13'h0001;
               if (tcnt_q == gdr_pkg::HDQ_SAMP_CYC) begin
                  run_d  = 1'b0;
                  sr_d   = {pin, sr_q[15:1]};
                  bitn_d = bitn_q + 5'h01;
                  // address goes out lsb first, the eighth bit selects write
                  if (bitn_q == 5'h07 && !pin) begin
                     st_d   = gdr_pkg::H_GAP;
                     addr_d = sr_q[15:9];
                     tcnt_d = 13'h0000;
                  end
                  if (bitn_q == 5'h0f) begin
                     wr_d.stb  = 1'b1;
                     wr_d.addr = sr_q[7:1];
                     wr_d.data = {pin, sr_q[15:9]};
                     st_d      = gdr_pkg::H_IDLE;
                  end
               end
            end
         end
         gdr_pkg::H_GAP: begin
            tcnt_d = tcnt_q + 13'h0001;
            if (tcnt_q == gdr_pkg::HDQ_RSP_CYC) begin
               st_d   = gdr_pkg::H_TX;
               sr_d   = {8'h00, rd_data_in};
               tcnt_d = 13'h0000;
               bitn_d = 5'h00;
            end
         end
         gdr_pkg::H_TX: begin
            oe_d   = tcnt_q < (sr_q[0] ? gdr_pkg::HDQ_STRT_CYC : gdr_pkg::HDQ_ZERO_CYC);
            tcnt_d = tcnt_q + 13'h0001;
            if (tcnt_q == gdr_pkg::HDQ_BIT_CYC - 13'h0001) begin
               tcnt_d = 13'h0000;
               sr_d   = {1'b0, sr_q[15:1]};
               bitn_d = bitn_q + 5'h01;
               if (bitn_q == 5'h07) begin
                  st_d = gdr_pkg::H_IDLE;
               end
            end
         end
         default: st_d = gdr_pkg::H_IDLE;
      endcase
      // a long low aborts whatever is going on; our own pulls stay well short of it
      if (low_q == gdr_pkg::HDQ_BRK_CYC) begin
         st_d  = gdr_pkg::H_IDLE;
         brk_d = 1'b1;
         oe_d  = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync_q      <= 3'h7;
         st_q        <= gdr_pkg::H_IDLE;
         tcnt_q      <= 13'h0000;
         low_q       <= 13'h0000;
         sr_q        <= 16'h0000;
         bitn_q      <= 5'h00;
         run_q       <= 1'b0;
         brk_q       <= 1'b0;
         addr_q      <= 7'h00;
         wr_out      <= '0;
         hdq_oe_out  <= 1'b0;
      end else begin
         sync_q      <= {sync_q[1:0], hdq_in};
         st_q        <= st_d;
         tcnt_q      <= tcnt_d;
         low_q       <= low_d;
         sr_q        <= sr_d;
         bitn_q      <= bitn_d;
         run_q       <= run_d;
         brk_q       <= brk_d;
         addr_q      <= addr_d;
         wr_out      <= wr_d;
         hdq_oe_out  <= oe_d;
      end
   end

   assign rd_addr_out = addr_q;
endmodule
`default_nettype wire

// ---- gdr_bank.sv ----
// gdr_bank: bank modulation windows and the low-battery blink phase
`timescale 1ns/10ps
`default_nettype none
module gdr_bank #(
   parameter int PERIOD = gdr_pkg::MOD_CYC,
   parameter int BLINK  = gdr_pkg::BLINK_HALF_CYC
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // windows
   output logic      bank_a_out,
   output logic      bank_b_out,
   output logic      blink_out
);
   localparam int ON   = (PERIOD * gdr_pkg::MOD_DUTY_PCT) / 100;
   localparam int HALF = PERIOD / 2;
   logic [31:0] mcnt_q, mcnt_d, bcnt_q, bcnt_d;
   logic        a_d, b_d, bl_d;

   always_comb begin
      mcnt_d = (mcnt_q == 32'(PERIOD - 1)) ? 32'h0 : mcnt_q + 32'h1;
      // windows sit half a period apart so the banks never overlap
      a_d    = mcnt_d < 32'(ON);
      b_d    = (mcnt_d >= 32'(HALF)) && (mcnt_d < 32'(HALF + ON));
      bcnt_d = (bcnt_q == 32'(BLINK - 1)) ? 32'h0 : bcnt_q + 32'h1;
      bl_d   = (bcnt_q == 32'(BLINK - 1)) ? ~blink_out : blink_out;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mcnt_q     <= 32'h0;
         bcnt_q     <= 32'h0;
         bank_a_out <= 1'b0;
         bank_b_out <= 1'b0;
         blink_out  <= 1'b0;
      end else begin
         mcnt_q     <= mcnt_d;
         bcnt_q     <= bcnt_d;
         bank_a_out <= a_d;
         bank_b_out <= b_d;
         blink_out  <= bl_d;
      end
   end

   a_bank_excl: assert property (@(posedge clk_in) disable iff (rst_in)
      !(bank_a_out && bank_b_out)) else $error("both banks active");
   a_bank_duty: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(bank_a_out) |-> bank_a_out[*8] ##1 (mcnt_q < 32'(ON))) else $error("bank window short");
endmodule
`default_nettype wire

// ---- gdr_top.sv ----
// gdr_top: registers, software reset, voltage refresh and led display control
`timescale 1ns/10ps
`default_nettype none
module gdr_top #(
   parameter int         P_BATTV_CYC = gdr_pkg::BATTV_CYC,
   parameter int         P_HOLD_CYC  = gdr_pkg::HOLD_CYC,
   parameter int         P_MOD_CYC   = gdr_pkg::MOD_CYC,
   parameter int         P_BLINK_CYC = gdr_pkg::BLINK_HALF_CYC,
   parameter logic [7:0] P_FULL_CAP  = gdr_pkg::FULL_CAP_DEF,
   parameter logic [7:0] P_LOW_V1    = gdr_pkg::LOW_V1_DEF
) (
   // clock and reset
   input  wire logic       MCLK_IN,
   input  wire logic       RST_IN,
   // serial port pin
   input  wire logic       HDQ_IN,
   output logic            HDQ_OUT,
   output logic            HDQ_OE_OUT,
   // measurement from the gauge core
   input  wire logic [7:0] BATTERY_SENSE_IN,
   input  wire logic       CHG_RATE_IN,
   input  wire logic       FAST_DSG_IN,
   // display control pin, sensed high and low
   input  wire logic       DCTL_HI_IN,
   input  wire logic       DCTL_LO_IN,
   // led drive
   output logic [4:0]      LED_SEGMENT_OUT,
   output logic            LED_COMMON_OUT
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   gdr_pkg::gdr_wr_t wr;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;
   logic [7:0]  avail_hi_q, avail_hi_d, avail_lo_q, avail_lo_d;
   logic [7:0]  meas_dsg_q, meas_dsg_d, out_ctl_q, out_ctl_d;
   logic [7:0]  load_comp_q, load_comp_d, battv_q, battv_d;
   logic [7:0]  prog_pin_q, prog_pin_d;
   logic        reset_ind_q, reset_ind_d, valid_dsg_q, valid_dsg_d;
   logic        abs_q, abs_d, armed_q, armed_d, srst;
   logic [31:0] sec_q, sec_d, hold_q, hold_d;
   logic [3:0]  dsy_q;
   logic        hi_s, lo_s, dctl_on, ovr_en, low_batt;
   logic        bank_a, bank_b, blink;
   logic [7:0]  full_ref;
   logic [4:0]  lit, show, led_d;
   logic        com_d;

   assign HDQ_OUT = 1'b0;
   assign hi_s    = dsy_q[1];
   assign lo_s    = dsy_q[3];
   assign ovr_en  = out_ctl_q[gdr_pkg::OVR_EN_BIT];

   function automatic logic pct_ge(input logic [7:0] num, input logic [7:0] dnm,
                                   input logic [6:0] pct);
      pct_ge = (16'(num) * 16'd100) >= (16'(dnm) * 16'(pct));
   endfunction

   // ------------------------------------------------------------
   // serial port and bank timing
   // ------------------------------------------------------------
   gdr_hdq u_hdq (
      .clk_in      (MCLK_IN),
      .rst_in      (RST_IN),
      .hdq_in      (HDQ_IN),
      .hdq_oe_out  (HDQ_OE_OUT),
      .rd_data_in  (rd_data),
      .rd_addr_out (rd_addr),
      .wr_out      (wr)
   );

   gdr_bank #(
      .PERIOD (P_MOD_CYC),
      .BLINK  (P_BLINK_CYC)
   ) u_bank (
      .clk_in     (MCLK_IN),
      .rst_in     (RST_IN),
      .bank_a_out (bank_a),
      .bank_b_out (bank_b),
      .blink_out  (blink)
   );

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   always_comb begin
      case (rd_addr)
         gdr_pkg::A_AVAIL_HI:  rd_data = avail_hi_q;
         gdr_pkg::A_AVAIL_LO:  rd_data = avail_lo_q;
         gdr_pkg::A_MEAS_DSG:  rd_data = meas_dsg_q;
         gdr_pkg::A_LOAD_COMP: rd_data = load_comp_q;
         gdr_pkg::A_PROG_PIN:  rd_data = prog_pin_q;
         gdr_pkg::A_BATT_V:    rd_data = battv_q;
         gdr_pkg::A_CTRL:      rd_data = {7'h00, abs_q};
         gdr_pkg::A_FLAGS:     rd_data = {6'h00, valid_dsg_q, reset_ind_q};
         default:              rd_data = 8'h00;
      endcase
   end

   always_comb begin
      avail_hi_d  = avail_hi_q;
      avail_lo_d  = avail_lo_q;
      meas_dsg_d  = meas_dsg_q;
      out_ctl_d   = out_ctl_q;
      load_comp_d = load_comp_q;
      prog_pin_d  = prog_pin_q;
      reset_ind_d = reset_ind_q;
      valid_dsg_d = valid_dsg_q;
      abs_d       = abs_q;
      armed_d     = armed_q;
      battv_d     = battv_q;
      srst        = 1'b0;
      if (wr.stb) begin
         // any other write between the two steps breaks the sequence
         armed_d = 1'b0;
         case (wr.addr)
            gdr_pkg::A_PROG_PIN: begin
               prog_pin_d = wr.data;
               armed_d    = (wr.data == gdr_pkg::RST_BYTE);
            end
            gdr_pkg::A_MEAS_DSG: begin
               meas_dsg_d = wr.data;
               srst       = armed_q && (wr.data == gdr_pkg::RST_BYTE);
            end
            gdr_pkg::A_AVAIL_HI:  avail_hi_d  = wr.data;
            gdr_pkg::A_AVAIL_LO:  avail_lo_d  = wr.data;
            gdr_pkg::A_LOAD_COMP: load_comp_d = wr.data;
            gdr_pkg::A_OUT_CTL:   out_ctl_d   = wr.data;
            gdr_pkg::A_CTRL:      abs_d       = wr.data[gdr_pkg::CTRL_ABS_BIT];
            gdr_pkg::A_FLAGS: begin
               reset_ind_d = wr.data[gdr_pkg::FLG_RESET_IND];
               valid_dsg_d = wr.data[gdr_pkg::FLG_VALID_DSG];
            end
            default: ;
         endcase
      end
      // code is the raw sense conversion: volts = 1.2 * code / 256
      if (sec_q == 32'(P_BATTV_CYC - 1)) begin
         battv_d = BATTERY_SENSE_IN;
      end
      // reset comes last so it wins over the write that triggered it
      if (srst) begin
         meas_dsg_d                       = P_FULL_CAP;
         avail_hi_d                       = gdr_pkg::RST_BYTE;
         avail_lo_d                       = gdr_pkg::RST_BYTE;
         load_comp_d                      = gdr_pkg::RST_BYTE;
         out_ctl_d[gdr_pkg::OVR_EN_BIT]   = 1'b0;
         valid_dsg_d                      = 1'b0;
         reset_ind_d                      = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         avail_hi_q  <= gdr_pkg::RST_BYTE;
         avail_lo_q  <= gdr_pkg::RST_BYTE;
         meas_dsg_q  <= P_FULL_CAP;
         out_ctl_q   <= gdr_pkg::RST_BYTE;
         load_comp_q <= gdr_pkg::RST_BYTE;
         prog_pin_q  <= gdr_pkg::RST_BYTE;
         battv_q     <= gdr_pkg::RST_BYTE;
         reset_ind_q <= 1'b1;
         valid_dsg_q <= 1'b0;
         abs_q       <= 1'b0;
         armed_q     <= 1'b0;
      end else begin
         avail_hi_q  <= avail_hi_d;
         avail_lo_q  <= avail_lo_d;
         meas_dsg_q  <= meas_dsg_d;
         out_ctl_q   <= out_ctl_d;
         load_comp_q <= load_comp_d;
         prog_pin_q  <= prog_pin_d;
         battv_q     <= battv_d;
         reset_ind_q <= reset_ind_d;
         valid_dsg_q <= valid_dsg_d;
         abs_q       <= abs_d;
         armed_q     <= armed_d;
      end
   end

   // ------------------------------------------------------------
   // display
   // ------------------------------------------------------------
   assign full_ref = abs_q ? P_FULL_CAP : meas_dsg_q;

   for (genvar k = 0; k < gdr_pkg::LED_N; k++) begin : g_lit
      assign lit[k] = pct_ge(avail_hi_q, full_ref, 7'((k + 1) * gdr_pkg::LED_STEP_PCT));
   end

   always_comb begin
      sec_d    = (sec_q == 32'(P_BATTV_CYC - 1)) ? 32'h0 : sec_q + 32'h1;
      // high wins; low reloads the hold time, float counts it away
      if (hi_s) begin
         hold_d = 32'h0;
      end else if (lo_s) begin
         hold_d = 32'(P_HOLD_CYC);
      end else begin
         hold_d = (hold_q != 32'h0) ? hold_q - 32'h1 : 32'h0;
      end
      dctl_on  = !hi_s && (lo_s || hold_q != 32'h0 || CHG_RATE_IN || FAST_DSG_IN);
      low_batt = (battv_q < P_LOW_V1) ||
                 !pct_ge(avail_hi_q, full_ref, 7'(gdr_pkg::LOW_PCT));
      show     = lit;
      if (low_batt) begin
         show[0] = blink;
      end
      led_d    = (show & (bank_a ? gdr_pkg::BANK_A_MASK : 5'h00)) |
                 (show & (bank_b ? gdr_pkg::BANK_B_MASK : 5'h00));
      com_d    = dctl_on && (bank_a || bank_b);
      if (!dctl_on) begin
         led_d = 5'h00;
      end
      // override shows the written pattern unmodulated for connection checks
      if (ovr_en) begin
         led_d = out_ctl_q[gdr_pkg::OVR_LED_LSB +: gdr_pkg::LED_N];
         com_d = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         sec_q           <= 32'h0;
         hold_q          <= 32'h0;
         dsy_q           <= 4'h0;
         LED_SEGMENT_OUT <= 5'h00;
         LED_COMMON_OUT  <= 1'b0;
      end else begin
         sec_q           <= sec_d;
         hold_q          <= hold_d;
         dsy_q           <= {dsy_q[2], DCTL_LO_IN, dsy_q[0], DCTL_HI_IN};
         LED_SEGMENT_OUT <= led_d;
         LED_COMMON_OUT  <= com_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_soft_rst_arm: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (wr.stb && wr.addr == gdr_pkg::A_PROG_PIN && wr.data == 8'h00) |=> armed_q)
      else $error("zero program pin write did not arm reset");
   a_soft_rst_seq: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (armed_q && wr.stb && wr.addr == gdr_pkg::A_MEAS_DSG && wr.data == 8'h00)
      |=> (reset_ind_q && meas_dsg_q == P_FULL_CAP && !armed_q))
      else $error("soft reset did not follow the sequence");
   a_rst_values: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      srst |=> (avail_hi_q == 8'h00 && avail_lo_q == 8'h00 && load_comp_q == 8'h00
                && !ovr_en && !valid_dsg_q))
      else $error("soft reset left a value set");
   a_battv_load: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (sec_q == 32'(P_BATTV_CYC - 1)) |=> (battv_q == $past(BATTERY_SENSE_IN)))
      else $error("battery voltage not refreshed");
   a_battv_steady: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (sec_q != 32'(P_BATTV_CYC - 1)) |=> $stable(battv_q))
      else $error("battery voltage changed between refreshes");
   a_dctl_high_off: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (hi_s && !ovr_en) |=> (LED_SEGMENT_OUT == 5'h00 && !LED_COMMON_OUT))
      else $error("leds lit with control pin high");
   a_dctl_low_on: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (lo_s && !hi_s && !ovr_en && bank_a) |=> LED_COMMON_OUT)
      else $error("leds dark with control pin low");
   a_hold_load: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (lo_s && !hi_s) ##1 (!lo_s && !hi_s) |-> (hold_q == 32'(P_HOLD_CYC)) ##1
      (hold_q == 32'(P_HOLD_CYC - 1)))
      else $error("hold time not started on release");
   a_hold_expire: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (!lo_s && !hi_s && hold_q == 32'h0 && !CHG_RATE_IN && !FAST_DSG_IN && !ovr_en)
      |=> (LED_SEGMENT_OUT == 5'h00 && !LED_COMMON_OUT))
      else $error("leds lit after hold time");
   a_bank_split: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      !ovr_en |=> !(|(LED_SEGMENT_OUT & gdr_pkg::BANK_A_MASK) &&
                    |(LED_SEGMENT_OUT & gdr_pkg::BANK_B_MASK)))
      else $error("both banks driven together");
   a_dctl_float: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (!lo_s && !hi_s && CHG_RATE_IN && !ovr_en && bank_b) |=> LED_COMMON_OUT)
      else $error("leds dark on fast charge with control pin floating");
   a_abs_full: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (abs_q && avail_hi_q >= P_FULL_CAP && battv_q >= P_LOW_V1 && dctl_on && !ovr_en
       && bank_a) |=> (LED_SEGMENT_OUT == gdr_pkg::BANK_A_MASK))
      else $error("absolute mode full charge not shown");
   a_low_blink: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      ((battv_q < P_LOW_V1 || (avail_hi_q == 8'h00 && full_ref != 8'h00)) && dctl_on
       && !ovr_en && bank_a) |=> (LED_SEGMENT_OUT[0] == $past(blink)))
      else $error("led one not following the blink phase on low battery");
endmodule
`default_nettype wire

// ---- gdr_host.sv ----
// gdr_host: host processor model driving the single-wire serial port
`timescale 1ns/10ps
`default_nettype none
module gdr_host (
   // clock
   input  wire logic clk_in,
   // level the host leaves on the wire
   output logic      line_out
);
   initial line_out = 1'b1;
   task automatic hold(input int lvl, input int n);
      line_out = lvl[0];
      repeat (n) @(negedge clk_in);
   endtask
   // a break before every transaction, bits lsb first, write flag after the address
   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [15:0] w;
      w = {data, 1'b1, addr};
      hold(0, 3810);
      hold(1, 800);
      for (int i = 0; i < 16; i++) begin
         hold(0, w[i] ? 100 : 1560);
         hold(1, w[i] ? 1520 : 60);
      end
      hold(1, 1600);
   endtask
endmodule
`default_nettype wire

// ---- tb_gdr_top.sv ----
// tb_gdr_top: display modes and software reset driven through the serial port
`timescale 1ns/10ps
`default_nettype none
module tb_gdr_top;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       line;
   logic       hdq_oe;
   logic       chg = 1'b0;
   logic       fdsg = 1'b0;
   logic       dhi = 1'b1;
   logic       dlo = 1'b0;
   logic [4:0] led_segment_output;
   logic [4:0] seen;
   logic       com;
   logic       com_seen;
   logic       oe_seen = 1'b0;
   int         fails = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   always #25 mclk = ~mclk;
   // the device must never pull the wire while the host writes
   always @(negedge mclk) oe_seen <= oe_seen | hdq_oe;
   gdr_host u_gdr_host (.clk_in(mclk), .line_out(line));
   gdr_top #(.P_BATTV_CYC(50), .P_HOLD_CYC(40), .P_MOD_CYC(40), .P_BLINK_CYC(30)) u_gdr_top (
      .MCLK_IN(mclk), .RST_IN(rst), .HDQ_IN(line & ~hdq_oe), .HDQ_OUT(), .HDQ_OE_OUT(hdq_oe),
      .BATTERY_SENSE_IN(8'hff), .CHG_RATE_IN(chg), .FAST_DSG_IN(fdsg), .DCTL_HI_IN(dhi),
      .DCTL_LO_IN(dlo), .LED_SEGMENT_OUT(led_segment_output), .LED_COMMON_OUT(com));
   task automatic check(input string what, input logic [4:0] got, input logic [4:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // banks light only part of each period, so collect the segments over a window
   task automatic watch(input int n);
      seen = 5'h00;
      com_seen = 1'b0;
      repeat (n) begin
         @(negedge mclk);
         seen = seen | led_segment_output;
         com_seen = com_seen | com;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // three serial writes take about 96400 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      // let the pin synchronisers see the tied-high level before a rate input lights anything
      repeat (4) @(negedge mclk);
      chg = 1'b1;
      watch(200);
      check("tied high", seen, 5'h00);
      check("tied high common", {4'h0, com_seen}, 5'h00);
      chg = 1'b0;
      dhi = 1'b0;
      dlo = 1'b1;
      // 73h against a c0h reference is just under 60 percent: two steps lit, not three
      u_gdr_host.wr(gdr_pkg::A_AVAIL_HI, 8'h73);
      watch(80);
      check("held low", seen, 5'h03);
      check("held low common", {4'h0, com_seen}, 5'h01);
      dlo = 1'b0;
      watch(30);
      check("hold after release", {4'h0, |seen}, 5'h01);
      repeat (30) @(negedge mclk);
      watch(80);
      check("hold expired", seen, 5'h00);
      check("hold expired common", {4'h0, com_seen}, 5'h00);
      chg = 1'b1;
      watch(80);
      check("charge rate", seen, 5'h03);
      chg = 1'b0;
      fdsg = 1'b1;
      watch(80);
      check("fast discharge", seen, 5'h03);
      fdsg = 1'b0;
      dlo = 1'b1;
      u_gdr_host.wr(gdr_pkg::A_PROG_PIN, gdr_pkg::RST_BYTE);
      u_gdr_host.wr(gdr_pkg::A_MEAS_DSG, gdr_pkg::RST_BYTE);
      watch(80);
      check("after soft reset", seen & 5'h1e, 5'h00);
      check("low charge blink", seen & 5'h01, 5'h01);
      check("no pull during writes", {4'h0, oe_seen}, 5'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
